// ===== src/bulk_nak_pkg.sv
package bulk_nak_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] NAK_CTRL_ADDR      = 16'hff62;
    localparam logic [15:0] NAK_MASK_ADDR      = 16'hff63;

    localparam logic [7:0]  NAK_CTRL_RESET     = 8'h00;
    localparam logic [7:0]  NAK_MASK_RESET     = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int          IN1_RELEASE_BIT    = 0;
    localparam int          OUT1_NAK_BIT       = 2;
    localparam int          OUT1_WR_EN_BIT     = 2;

    // ************************************************************
    // fifo geometry and timing
    // ************************************************************
    localparam int          IN_FIFO_DEPTH      = 64;
    localparam int          DATA_WIDTH         = 8;
    localparam int          CLEAR_SETTLE_CLKS  = 5;
    localparam int          CLEAR_GAP_CLKS     = 4;

    // ************************************************************
    // bus-side bank state
    // ************************************************************
    typedef enum logic [0:0] {
        BUS_BANK_EMPTY  = 1'b0,
        BUS_BANK_LOADED = 1'b1
    } bus_bank_state_t;

endpackage

// ===== src/bank_ram.sv
module bank_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128
) (
    input  wire logic                     core_clk,  // clock
    input  wire logic                     wr_en,     // write strobe
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,   // write address
    input  wire logic [WIDTH-1:0]         wr_data,   // write data
    input  wire logic                     rd_en,     // read strobe
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,   // read address
    output logic      [WIDTH-1:0]         rd_data    // registered read data
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 2) begin : g_bad_depth
        $error("bank_ram depth must be at least 2");
    end

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data come from a register, one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ===== src/bulk_nak_ctrl.sv
module bulk_nak_ctrl #(
    parameter int DEPTH = bulk_nak_pkg::IN_FIFO_DEPTH
) (
    input  wire logic                      core_clk,         // 250 MHz usb clock
    input  wire logic                      rstn,             // synchronous reset, active low
    input  wire logic [15:0]               reg_addr,         // register address
    input  wire logic [7:0]                reg_wdata,        // register write data
    input  wire logic                      reg_wr,           // register write strobe
    input  wire logic                      reg_rd,           // register read strobe
    output logic      [7:0]                reg_rdata,        // read data, next cycle
    input  wire logic                      fifo_wr,          // cpu byte write into in fifo
    input  wire logic [7:0]                fifo_wdata,       // cpu byte
    output logic                           fifo_full,        // cpu bank cannot take bytes
    input  wire logic                      end_of_data,      // bulk_in1_end_of_data pulse
    input  wire logic                      in_fifo_clear,    // in fifo clear pulse
    input  wire logic                      out_fifo_clear,   // out fifo clear pulse
    input  wire logic                      ep1_in_enabled,   // in endpoint mapped and active
    input  wire logic                      ep1_out_enabled,  // out endpoint mapped and active
    input  wire logic                      ep0_rx_nak_busy,  // nak going out on ep0 receive
    input  wire logic                      ep2_nak_busy,     // nak going out on endpoint 2
    input  wire logic                      sie_rd,           // sie takes one byte of bus bank
    output logic      [7:0]                sie_rdata,        // byte, one cycle after sie_rd
    input  wire logic                      sie_retry,        // rewind bus bank for resend
    input  wire logic                      sie_ack,          // host acked the packet
    output logic      [$clog2(DEPTH):0]    sie_byte_count,   // bytes held in bus bank
    output logic                           in_nak_release,   // 1 lets in data go
    input  wire logic                      out_bank_busy,    // bus-side out bank cannot accept
    input  wire logic                      out_bank_toggle,  // out bank toggle pulse
    output logic                           out_nak           // 1 forces nak on bulk out
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("bulk_nak_ctrl depth must be a power of two of at least 2");
    end

    // ************************************************************
    // state
    // ************************************************************
    logic                          release_reg;
    logic                          release_next;
    logic                          out_nak_reg;
    logic                          out_nak_next;
    logic                          out_wr_en_reg;
    logic                          out_wr_en_next;
    logic [7:0]                    rdata_reg;
    logic [7:0]                    rdata_next;
    logic                          cpu_bank_reg;
    logic [CW-1:0]                 cpu_cnt_reg;
    logic [CW-1:0]                 cpu_cnt_next;
    logic                          eod_reg;
    logic                          eod_next;
    logic [CW-1:0]                 bus_cnt_reg;
    logic [CW-1:0]                 bus_cnt_next;
    logic [AW-1:0]                 rd_ptr_reg;
    logic [AW-1:0]                 rd_ptr_next;
    logic                          full_reg;
    bulk_nak_pkg::bus_bank_state_t bus_state_reg;
    bulk_nak_pkg::bus_bank_state_t bus_state_next;

    // ************************************************************
    // register decode
    // ************************************************************
    wire sel_ctrl = reg_addr == bulk_nak_pkg::NAK_CTRL_ADDR;
    wire sel_mask = reg_addr == bulk_nak_pkg::NAK_MASK_ADDR;
    wire wr_ctrl  = reg_wr & sel_ctrl;
    wire wr_mask  = reg_wr & sel_mask;

    // out nak write lands only with its enable set and not with naks in flight on both ep0 receive and ep2
    wire out_nak_wr_ok = wr_ctrl & out_wr_en_reg & ~(ep0_rx_nak_busy & ep2_nak_busy);

    wire [7:0] ctrl_view = 8'h00
                         | ({7'h00, release_reg} << bulk_nak_pkg::IN1_RELEASE_BIT)
                         | ({7'h00, out_nak_reg} << bulk_nak_pkg::OUT1_NAK_BIT);
    wire [7:0] mask_view = {7'h00, out_wr_en_reg} << bulk_nak_pkg::OUT1_WR_EN_BIT;

    // ************************************************************
    // in fifo bank control
    // ************************************************************
    wire cpu_done  = (cpu_cnt_reg == FULL_COUNT) | eod_reg;
    wire bus_empty = bus_cnt_reg == {CW{1'b0}};
    // swap needs a finished cpu bank and a drained bus bank
    wire toggle    = cpu_done & bus_empty & ~in_fifo_clear & ep1_in_enabled;
    wire cpu_take  = fifo_wr & ~full_reg & ~in_fifo_clear;
    wire sie_take  = sie_rd & (CW'(rd_ptr_reg) < bus_cnt_reg) & ~in_fifo_clear;
    wire [AW:0] wr_addr = {cpu_bank_reg, cpu_cnt_reg[AW-1:0]};
    wire [AW:0] rd_addr = {~cpu_bank_reg, rd_ptr_reg};

    always_comb begin
        cpu_cnt_next   = cpu_cnt_reg;
        eod_next       = eod_reg;
        bus_cnt_next   = bus_cnt_reg;
        rd_ptr_next    = rd_ptr_reg;
        bus_state_next = bus_state_reg;
        if (in_fifo_clear) begin
            cpu_cnt_next   = {CW{1'b0}};
            eod_next       = 1'b0;
            bus_cnt_next   = {CW{1'b0}};
            rd_ptr_next    = {AW{1'b0}};
            bus_state_next = bulk_nak_pkg::BUS_BANK_EMPTY;
        end else if (toggle) begin
            cpu_cnt_next   = {CW{1'b0}};
            // an end of data in the swap cycle closes the next packet
            eod_next       = end_of_data;
            bus_cnt_next   = cpu_cnt_reg;
            rd_ptr_next    = {AW{1'b0}};
            bus_state_next = bulk_nak_pkg::BUS_BANK_LOADED;
        end else begin
            if (cpu_take) begin
                cpu_cnt_next = cpu_cnt_reg + CW'(1);
            end
            if (end_of_data) begin
                eod_next = 1'b1;
            end
            case (bus_state_reg)
                bulk_nak_pkg::BUS_BANK_LOADED: begin
                    // bank stays intact until the host acks; a retry rewinds
                    if (sie_ack) begin
                        bus_cnt_next   = {CW{1'b0}};
                        rd_ptr_next    = {AW{1'b0}};
                        bus_state_next = bulk_nak_pkg::BUS_BANK_EMPTY;
                    end else if (sie_retry) begin
                        rd_ptr_next = {AW{1'b0}};
                    end else if (sie_take) begin
                        rd_ptr_next = rd_ptr_reg + AW'(1);
                    end
                end
                default: begin
                    rd_ptr_next = {AW{1'b0}};
                end
            endcase
        end
    end

    // ************************************************************
    // nak bits
    // ************************************************************
    always_comb begin
        release_next = release_reg;
        if (!ep1_in_enabled) begin
            release_next = 1'b0;
        end else if (in_fifo_clear) begin
            release_next = 1'b0;
        end else if (toggle) begin
            release_next = 1'b1;
        end else if (bus_cnt_next == {CW{1'b0}}) begin
            release_next = 1'b0;
        end
    end

    // hardware set beats both the toggle clear and a firmware write
    always_comb begin
        out_nak_next = out_nak_reg;
        if (out_nak_wr_ok) begin
            out_nak_next = reg_wdata[bulk_nak_pkg::OUT1_NAK_BIT];
        end
        if (out_bank_toggle || out_fifo_clear) begin
            out_nak_next = 1'b0;
        end
        if (out_bank_busy) begin
            out_nak_next = 1'b1;
        end
        if (!ep1_out_enabled) begin
            out_nak_next = 1'b0;
        end
    end

    assign out_wr_en_next = wr_mask ? reg_wdata[bulk_nak_pkg::OUT1_WR_EN_BIT] : out_wr_en_reg;
    assign rdata_next     = !reg_rd ? rdata_reg : sel_ctrl ? ctrl_view : sel_mask ? mask_view : 8'h00;

    // ************************************************************
    // flops
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            release_reg <= bulk_nak_pkg::NAK_CTRL_RESET[bulk_nak_pkg::IN1_RELEASE_BIT];
        end else begin
            release_reg <= release_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            out_nak_reg <= bulk_nak_pkg::NAK_CTRL_RESET[bulk_nak_pkg::OUT1_NAK_BIT];
        end else begin
            out_nak_reg <= out_nak_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            out_wr_en_reg <= bulk_nak_pkg::NAK_MASK_RESET[bulk_nak_pkg::OUT1_WR_EN_BIT];
        end else begin
            out_wr_en_reg <= out_wr_en_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cpu_bank_reg <= 1'b0;
        end else begin
            cpu_bank_reg <= toggle ? ~cpu_bank_reg : cpu_bank_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cpu_cnt_reg <= {CW{1'b0}};
        end else begin
            cpu_cnt_reg <= cpu_cnt_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            eod_reg <= 1'b0;
        end else begin
            eod_reg <= eod_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bus_cnt_reg <= {CW{1'b0}};
        end else begin
            bus_cnt_reg <= bus_cnt_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_ptr_reg <= {AW{1'b0}};
        end else begin
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bus_state_reg <= bulk_nak_pkg::BUS_BANK_EMPTY;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // full flag looks ahead so a write in the toggle cycle is never lost
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            full_reg <= 1'b0;
        end else begin
            full_reg <= (cpu_cnt_next == FULL_COUNT) | eod_next;
        end
    end

    // ************************************************************
    // bank storage, both banks in one memory
    // ************************************************************
    bank_ram #(
        .WIDTH (bulk_nak_pkg::DATA_WIDTH),
        .DEPTH (2 * DEPTH)
    ) u_bank_ram (
        .core_clk (core_clk),
        .wr_en    (cpu_take),
        .wr_addr  (wr_addr),
        .wr_data  (fifo_wdata),
        .rd_en    (sie_take),
        .rd_addr  (rd_addr),
        .rd_data  (sie_rdata)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata      = rdata_reg;
    assign fifo_full      = full_reg;
    assign sie_byte_count = bus_cnt_reg;
    assign in_nak_release = release_reg;
    assign out_nak        = out_nak_reg;

endmodule

// ===== testbench/bulk_nak_ctrl_monitor.sv
module bulk_nak_ctrl_monitor #(
    parameter int DEPTH = bulk_nak_pkg::IN_FIFO_DEPTH
) (
    input wire logic                   core_clk,        // clock
    input wire logic                   rstn,            // reset, active low
    input wire logic [15:0]            reg_addr,        // register address
    input wire logic [7:0]             reg_wdata,       // write data
    input wire logic                   reg_wr,          // write strobe
    input wire logic                   reg_rd,          // read strobe
    input wire logic [7:0]             reg_rdata,       // read data
    input wire logic                   in_fifo_clear,   // in clear
    input wire logic                   out_fifo_clear,  // out clear
    input wire logic                   ep1_in_enabled,  // in valid
    input wire logic                   ep1_out_enabled, // out valid
    input wire logic                   ep0_rx_nak_busy, // ep0 nak
    input wire logic                   ep2_nak_busy,    // ep2 nak
    input wire logic [$clog2(DEPTH):0] sie_byte_count,  // bus bank count
    input wire logic                   in_nak_release,  // in release
    input wire logic                   out_bank_busy,   // out bank busy
    input wire logic                   out_bank_toggle, // out toggle
    input wire logic                   out_nak          // out nak
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mask_reg;
    wire  ctrl_wr = reg_wr && reg_addr == bulk_nak_pkg::NAK_CTRL_ADDR && ep1_out_enabled
                    && !out_bank_busy && !out_bank_toggle && !out_fifo_clear;
    wire  both_busy = ep0_rx_nak_busy && ep2_nak_busy;
    always_ff @(posedge core_clk) begin
        if (!rstn) mask_reg <= 1'b0;
        else if (reg_wr && reg_addr == bulk_nak_pkg::NAK_MASK_ADDR) mask_reg <= reg_wdata[2];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_reset; $rose(rstn) |-> !in_nak_release && !out_nak && sie_byte_count == 0; endproperty
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    property p_clear; in_fifo_clear |=> !in_nak_release && sie_byte_count == 0; endproperty
    a_clear: assert property (p_clear) else $error("in clear did not empty");
    property p_in_off; !ep1_in_enabled ##1 !ep1_in_enabled |-> !in_nak_release; endproperty
    a_in_off: assert property (p_in_off) else $error("release while in disabled");
    property p_out_off; !ep1_out_enabled ##1 !ep1_out_enabled |-> !out_nak; endproperty
    a_out_off: assert property (p_out_off) else $error("out nak while out disabled");
    property p_busy; ep1_out_enabled && out_bank_busy |=> out_nak; endproperty
    a_busy: assert property (p_busy) else $error("busy out bank without nak");
    property p_toggle;
        ep1_out_enabled && !out_bank_busy && (out_bank_toggle || out_fifo_clear) |=> !out_nak;
    endproperty
    a_toggle: assert property (p_toggle) else $error("out nak kept over toggle");
    property p_masked; ctrl_wr && (!mask_reg || both_busy) |=> $stable(out_nak); endproperty
    a_masked: assert property (p_masked) else $error("refused write changed out nak");
    property p_wr_ok; ctrl_wr && mask_reg && !both_busy |=> out_nak == $past(reg_wdata[2]); endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("allowed write lost");
    property p_fall; $fell(in_nak_release) |-> sie_byte_count == 0 || !$past(ep1_in_enabled); endproperty
    a_fall: assert property (p_fall) else $error("release cleared with data left");
    property p_rise; $rose(in_nak_release) |-> $past(sie_byte_count) == 0; endproperty
    a_rise: assert property (p_rise) else $error("toggle with bus bank loaded");
    property p_read;
        reg_rd && reg_addr == bulk_nak_pkg::NAK_CTRL_ADDR |=> reg_rdata
            == {5'h00, $past(out_nak), 1'b0, $past(in_nak_release)};
    endproperty
    a_read: assert property (p_read) else $error("control read wrong");
    c_toggle: cover property ($rose(in_nak_release));
    c_out: cover property ($rose(out_nak));
    c_clear: cover property (in_fifo_clear && in_nak_release);
endmodule

bind bulk_nak_ctrl bulk_nak_ctrl_monitor #(.DEPTH(DEPTH)) u_bulk_nak_ctrl_monitor (.*);

// ===== testbench/host_sie_model.sv
module host_sie_model (
    input  wire logic       core_clk,       // clock
    input  wire logic       rstn,           // reset, active low
    input  wire logic       go,             // host polls in endpoint
    input  wire logic       in_nak_release, // device lets data go
    input  wire logic [6:0] sie_byte_count, // bytes in bus bank
    input  wire logic [7:0] sie_rdata,      // byte read
    output logic            sie_rd,         // byte fetch
    output logic            sie_ack,        // host ack
    output logic [15:0]     byte_sum        // sum of bytes taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] n;
    logic       pend;
    // host takes the whole packet, then acks; nak (release 0) just means poll again
    always @(posedge core_clk) begin
        pend <= sie_rd;
        if (pend) byte_sum <= byte_sum + 16'(sie_rdata);
        sie_rd <= 1'b0;
        sie_ack <= 1'b0;
        if (!rstn) begin
            n <= 7'h00;
            pend <= 1'b0;
            byte_sum <= 16'h0000;
        end else if (go && in_nak_release && !sie_ack && !sie_rd && !pend) begin
            if (n < sie_byte_count) begin
                sie_rd <= 1'b1;
                n <= n + 7'h01;
            end else begin
                sie_ack <= 1'b1;
                n <= 7'h00;
            end
        end
    end
endmodule

// ===== testbench/bulk_nak_ctrl_bench.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module bulk_nak_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, fifo_wr = 0, end_of_data = 0, go = 0;
    logic in_fifo_clear = 0, out_fifo_clear = 0, ep1_in_enabled = 1, ep1_out_enabled = 1;
    logic ep0_rx_nak_busy = 0, ep2_nak_busy = 0, out_bank_busy = 0, out_bank_toggle = 0;
    logic [15:0] reg_addr = 16'h0000, byte_sum;
    logic [7:0]  reg_wdata = 8'h00, fifo_wdata = 8'h00, reg_rdata, sie_rdata;
    logic [6:0]  sie_byte_count;
    logic        fifo_full, sie_rd, sie_ack, in_nak_release, out_nak;
    int          error_cnt = 0, n_compared = 0;
    bulk_nak_ctrl u_bulk_nak_ctrl (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fifo_wr, .fifo_wdata, .fifo_full, .end_of_data, .in_fifo_clear, .out_fifo_clear, .ep1_in_enabled,
        .ep1_out_enabled, .ep0_rx_nak_busy, .ep2_nak_busy, .sie_rd, .sie_rdata, .sie_retry(1'b0), .sie_ack,
        .sie_byte_count, .in_nak_release, .out_bank_busy, .out_bank_toggle, .out_nak);
    host_sie_model u_host_sie_model (.core_clk, .rstn, .go, .in_nak_release, .sie_byte_count, .sie_rdata,
        .sie_rd, .sie_ack, .byte_sum);
    initial forever #2 core_clk = ~core_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tick(1); reg_wr = 1; reg_addr = a; reg_wdata = d;
        tick(1); reg_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        tick(1); reg_rd = 1; reg_addr = a;
        tick(1); reg_rd = 0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic put(input int n, input logic [7:0] base, input logic eod);
        for (int i = 0; i < n; i++) begin
            tick(1); fifo_wr = 1; fifo_wdata = base + 8'(i);
        end
        tick(1); fifo_wr = 0; end_of_data = eod;
        tick(1); end_of_data = 0;
        tick(2);
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        tick(2); rstn = 1;
        rd(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h00);
        rd(bulk_nak_pkg::NAK_MASK_ADDR, 8'h00);
        rd(16'hff64, 8'h00);
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h01); rd(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h00);
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); `CHK("out_nak", 1'b0, out_nak)
        wr(bulk_nak_pkg::NAK_MASK_ADDR, 8'h04); rd(bulk_nak_pkg::NAK_MASK_ADDR, 8'h04);
        ep0_rx_nak_busy = 1; ep2_nak_busy = 1;
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); `CHK("out_nak", 1'b0, out_nak)
        ep2_nak_busy = 0;
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); `CHK("out_nak", 1'b1, out_nak)
        rd(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04);
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h00); `CHK("out_nak", 1'b0, out_nak)
        out_bank_busy = 1; tick(2); `CHK("out_nak", 1'b1, out_nak)
        out_bank_busy = 0; out_bank_toggle = 1; tick(1); out_bank_toggle = 0; tick(1);
        `CHK("out_nak", 1'b0, out_nak)
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); `CHK("out_nak", 1'b1, out_nak)
        out_fifo_clear = 1; tick(1); out_fifo_clear = 0; tick(1);
        `CHK("out_nak", 1'b0, out_nak)
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); `CHK("out_nak", 1'b1, out_nak)
        ep1_out_enabled = 0;
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); tick(1); `CHK("out_nak", 1'b0, out_nak)
        ep1_out_enabled = 1;
        // short packet waits in bus bank while the cpu bank fills behind it
        put(3, 8'h11, 1'b1);
        `CHK("in_nak_release", 1'b1, in_nak_release)
        `CHK("sie_byte_count", 7'd3, sie_byte_count)
        put(bulk_nak_pkg::IN_FIFO_DEPTH, 8'h00, 1'b0);
        `CHK("fifo_full", 1'b1, fifo_full)
        `CHK("sie_byte_count", 7'd3, sie_byte_count)
        go = 1;
        for (int i = 0; i < 200 && sie_byte_count !== 7'd64; i++) tick(1);
        `CHK("sie_byte_count", 7'd64, sie_byte_count)
        `CHK("in_nak_release", 1'b1, in_nak_release)
        for (int i = 0; i < 400 && sie_byte_count !== 7'd0; i++) tick(1);
        tick(2);
        `CHK("in_nak_release", 1'b0, in_nak_release)
        `CHK("byte_sum", 16'h0816, byte_sum)
        go = 0;
        put(2, 8'h40, 1'b1);
        `CHK("in_nak_release", 1'b1, in_nak_release)
        in_fifo_clear = 1; tick(1); in_fifo_clear = 0;
        `CHK("in_nak_release", 1'b0, in_nak_release)
        tick(bulk_nak_pkg::CLEAR_GAP_CLKS);
        rd(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h00);
        put(1, 8'h55, 1'b1);
        `CHK("in_nak_release", 1'b1, in_nak_release)
        ep1_in_enabled = 0; tick(2);
        `CHK("in_nak_release", 1'b0, in_nak_release)
        ep1_in_enabled = 1;
        // mid-run reset must drop a set out nak and the write mask
        wr(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h04); `CHK("out_nak", 1'b1, out_nak)
        rstn = 0; tick(2); rstn = 1;
        rd(bulk_nak_pkg::NAK_CTRL_ADDR, 8'h00);
        rd(bulk_nak_pkg::NAK_MASK_ADDR, 8'h00);
        tally_and_finish();
    end
endmodule
